/* File: pbs_pkg.sv */
// shared constants and types of the pipelined burst sram front end
package pbs_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int WORDS = 65536;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SYNC_STAGES = 3;
  // sleep entry and exit, in clock periods
  localparam int SLEEP_CYCLES = 2;

  // ----------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // synchronous pins, all sampled on the rising clock edge
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic processorAddrStrobeN;
    logic controllerAddrStrobeN;
    logic burstAdvanceN;
    logic chipSelPipeN;
    logic chipSelDepthHi;
    logic chipSelDepthN;
    logic globalWriteN;
    logic byteWriteEnableN;
    logic [LANES-1:0] byteLaneSelectN;
  } pbs_bus_type;

  // asynchronous pins: output enable, sleep, burst order strap
  typedef struct packed {
    logic outputEnableN;
    logic sleepRequest;
    logic burstOrderHi;
  } pbs_async_type;

  // kind of array access made at an edge
  typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} pbs_access_type;

  // reset images: all strobes and writes inactive
  localparam pbs_bus_type BUS_IDLE = '1;
  // outputs off, awake, interleaved order
  localparam pbs_async_type ASYNC_IDLE = 3'h5;

endpackage

/* File: pbs_pin_sync.sv */
// three flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pbs_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  import pbs_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] held;
  } pbs_sync_type;

  pbs_sync_type st_q;
  pbs_sync_type st_d;
  logic [W-1:0] agree;

  // bits where the two late stages match
  assign agree = ~(st_q.s2 ^ st_q.s3);

  // shift chain, held value follows agreeing bits only
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.held = (agree & st_q.s3) | (~agree & st_q.held);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= '{s1: RST, s2: RST, s3: RST, held: RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign pinOut = st_q.held;

endmodule
`default_nettype wire

/* File: pbs_burst_step.sv */
// low address pair of a burst step, linear or interleaved
`timescale 1ns/1ps
`default_nettype none
module pbs_burst_step (
  input wire logic linearOrder,
  input wire logic [pbs_pkg::BURST_W-1:0] startLow,
  input wire logic [pbs_pkg::BURST_W-1:0] stepCount,
  output logic [pbs_pkg::BURST_W-1:0] addrLow
);
  import pbs_pkg::*;

  // both orders wrap within the two bits
  always_comb begin
    if (linearOrder) begin
      addrLow = BURST_W'(startLow + stepCount);
    end else begin
      addrLow = startLow ^ stepCount;
    end
  end

endmodule
`default_nettype wire

/* File: pbs_sram_top.sv */
// pipelined burst synchronous sram: input stage, burst logic, array, outputs
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire pbs_pkg::pbs_bus_type busIn,
  input wire logic outputEnableN,
  input wire logic sleepRequest,
  input wire logic burstOrderHi,
  output logic [pbs_pkg::DATA_W-1:0] dqOut,
  output logic dqOe
);
  import pbs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pbs_bus_type pins;
    logic [ADDR_W-1:0] baseAddr;
    logic [BURST_W-1:0] burstCnt;
    logic selected;
    logic [ADDR_W-1:0] accAddr;
    pbs_access_type lastAcc;
    logic outEn;
  } pbs_state_type;

  pbs_state_type st_q;
  pbs_state_type st_d;

  pbs_bus_type pin;
  pbs_async_type asyncPins;
  pbs_async_type asyncNow;
  logic sleepNow;
  logic linearOrder;
  logic procStrobe;
  logic ctrlStrobe;
  logic addrLoad;
  logic selNew;
  logic advance;
  logic [LANES-1:0] laneMask;
  logic writeReq;
  logic wrNow;
  logic rdNow;
  logic [BURST_W-1:0] cntNext;
  logic [BURST_W-1:0] startNext;
  logic [BURST_W-1:0] lowNext;
  logic [ADDR_W-BURST_W-1:0] highNext;
  logic [ADDR_W-1:0] accAddrNext;

  // ----------------------------------------------------------------
  // asynchronous pins
  // ----------------------------------------------------------------
  // output enable, sleep and strap all cross through four flops
  assign asyncPins = '{outputEnableN: outputEnableN,
                       sleepRequest: sleepRequest,
                       burstOrderHi: burstOrderHi};

  pbs_pin_sync #(
    .W(3),
    .RST(ASYNC_IDLE)
  ) uAsyncSync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pinIn(asyncPins),
    .pinOut(asyncNow)
  );

  assign sleepNow = asyncNow.sleepRequest;
  // strap is static, a floating pin reads high
  assign linearOrder = !asyncNow.burstOrderHi;

  // ----------------------------------------------------------------
  // strobe and select decode on the registered pins
  // ----------------------------------------------------------------
  assign pin = st_q.pins;

  // processor strobe counts only with select one low
  assign procStrobe = !pin.processorAddrStrobeN && !pin.chipSelPipeN;
  // controller strobe is shadowed by a valid processor strobe
  assign ctrlStrobe = !pin.controllerAddrStrobeN && !procStrobe;
  assign addrLoad = (procStrobe || ctrlStrobe) && !sleepNow;
  assign selNew = !pin.chipSelPipeN && pin.chipSelDepthHi &&
                  !pin.chipSelDepthN;

  // ----------------------------------------------------------------
  // write controls
  // ----------------------------------------------------------------
  // global write overrides the byte controls
  always_comb begin
    if (!pin.globalWriteN) begin
      laneMask = LANES_ALL;
    end else if (!pin.byteWriteEnableN) begin
      laneMask = ~pin.byteLaneSelectN;
    end else begin
      laneMask = LANES_NONE;
    end
  end

  assign writeReq = (laneMask != LANES_NONE);

  // processor strobe edge never writes; controller strobe writes now
  assign wrNow = !sleepNow && writeReq &&
                 (addrLoad ? (ctrlStrobe && selNew)
                           : st_q.selected);
  assign rdNow = !sleepNow && !wrNow &&
                 (addrLoad ? selNew : st_q.selected);

  // ----------------------------------------------------------------
  // burst address generation
  // ----------------------------------------------------------------
  // advance ignored on a load edge and while deselected
  assign advance = !addrLoad && !sleepNow && st_q.selected &&
                   !pin.burstAdvanceN;

  always_comb begin
    if (addrLoad) begin
      cntNext = STEP_ZERO;
    end else if (advance) begin
      cntNext = BURST_W'(st_q.burstCnt + STEP_ONE);
    end else begin
      cntNext = st_q.burstCnt;
    end
  end

  assign startNext = addrLoad ? pin.addr[BURST_W-1:0]
                              : st_q.baseAddr[BURST_W-1:0];
  assign highNext = addrLoad ? pin.addr[ADDR_W-1:BURST_W]
                             : st_q.baseAddr[ADDR_W-1:BURST_W];

  pbs_burst_step uStep (
    .linearOrder(linearOrder),
    .startLow(startNext),
    .stepCount(cntNext),
    .addrLow(lowNext)
  );

  assign accAddrNext = {highNext, lowNext};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // every synchronous pin lands in the input register
    st_d.pins = busIn;
    if (!sleepNow) begin
      if (addrLoad) begin
        st_d.baseAddr = pin.addr;
        st_d.selected = selNew;
      end
      st_d.burstCnt = cntNext;
      st_d.accAddr = accAddrNext;
    end
    // sleep freezes the counter and address, nothing is accessed
    if (wrNow) begin
      st_d.lastAcc = ACC_WRITE;
    end else if (rdNow) begin
      st_d.lastAcc = ACC_READ;
    end else begin
      st_d.lastAcc = ACC_NONE;
    end
    // drive only data of a read made at the previous edge; an access
    // coming out of deselect has none, so its first clock stays off
    st_d.outEn = (st_q.lastAcc == ACC_READ) && !wrNow && !sleepNow &&
                 !asyncNow.outputEnableN;
  end

  // state register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= '{pins: BUS_IDLE,
                baseAddr: '0,
                burstCnt: STEP_ZERO,
                selected: 1'h0,
                accAddr: '0,
                lastAcc: ACC_NONE,
                outEn: 1'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign dqOe = st_q.outEn;

  // ----------------------------------------------------------------
  // array, one memory per byte lane
  // ----------------------------------------------------------------
  // write lands one edge after the pins are registered, the read
  // register fills one edge after the access: pins, access, data
  // makes the first word three clocks, later words one each
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      logic [LANE_W-1:0] cells [WORDS];
      logic [LANE_W-1:0] readQ;

      // self-timed write of the selected lane, pipelined read
      always_ff @(posedge mclk) begin
        if (wrNow && laneMask[g]) begin
          cells[accAddrNext] <= pin.data[g*LANE_W +: LANE_W];
        end
        if (!reset_n) begin
          readQ <= '0;
        end else if (!sleepNow) begin
          readQ <= cells[st_q.accAddr];
        end
      end

      assign dqOut[g*LANE_W +: LANE_W] = readQ;
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // processor strobe start on a selecting address
  sequence sProcStart;
    procStrobe && selNew && !sleepNow;
  endsequence

  // second edge of a processor write, address held
  sequence sProcSecond;
    writeReq && pin.processorAddrStrobeN && pin.controllerAddrStrobeN &&
    pin.burstAdvanceN && !sleepNow;
  endsequence

  // controller strobe write on a selecting address
  sequence sCtrlWrite;
    ctrlStrobe && selNew && writeReq && !sleepNow;
  endsequence

  // read that brings the device out of deselect
  sequence sEmerge;
    addrLoad && selNew && !writeReq && !st_q.selected;
  endsequence

  a_load_addr: assert property (addrLoad |=>
    st_q.baseAddr == $past(pin.addr) && st_q.burstCnt == STEP_ZERO)
    else $error("address not loaded on strobe");

  a_burst_start: assert property (addrLoad |=>
    st_q.accAddr[BURST_W-1:0] == $past(pin.addr[BURST_W-1:0]))
    else $error("burst start pair wrong");

  a_adv_step: assert property (advance |=>
    st_q.burstCnt == BURST_W'($past(st_q.burstCnt) + STEP_ONE))
    else $error("burst counter did not step");

  a_hold_addr: assert property (
    (!addrLoad && pin.burstAdvanceN) |=> $stable(st_q.accAddr))
    else $error("address moved without strobe or advance");

  a_proc_wins: assert property (
    (!pin.processorAddrStrobeN && !pin.chipSelPipeN &&
     !pin.controllerAddrStrobeN) |-> !wrNow)
    else $error("controller strobe acted over processor strobe");

  a_proc_ignored: assert property (
    (!pin.processorAddrStrobeN && pin.chipSelPipeN &&
     pin.controllerAddrStrobeN) |=>
    $stable(st_q.baseAddr) && $stable(st_q.selected))
    else $error("processor strobe taken with select one high");

  a_gw_lanes: assert property (
    !pin.globalWriteN |-> laneMask == LANES_ALL)
    else $error("global write missed a lane");

  a_proc_write: assert property (
    sProcStart ##1 sProcSecond |-> wrNow && accAddrNext == $past(pin.addr))
    else $error("processor write not done on second edge");

  a_ctrl_write: assert property (sCtrlWrite |-> wrNow)
    else $error("controller write not done on strobe edge");

  a_emerge_off: assert property (sEmerge |=> !dqOe)
    else $error("outputs driven in first clock after deselect");

  a_write_hiz: assert property (wrNow |=> !dqOe)
    else $error("outputs driven during a write");

  a_sleep_quiet: assert property (
    sleepNow |=> !dqOe && $stable(st_q.accAddr))
    else $error("activity while asleep");

  a_read_drive: assert property (
    (st_q.lastAcc == ACC_READ && !wrNow && !sleepNow &&
     !asyncNow.outputEnableN) |=> dqOe)
    else $error("read data not driven with output enable low");

  a_byte_lanes: assert property (
    (pin.globalWriteN && !pin.byteWriteEnableN) |->
    laneMask == ~pin.byteLaneSelectN)
    else $error("byte lanes not taken from the lane selects");

  a_byte_off: assert property (
    (pin.globalWriteN && pin.byteWriteEnableN) |-> !wrNow)
    else $error("write made with both write enables high");

  a_desel_idle: assert property (
    (addrLoad && !selNew) |=> !st_q.selected && st_q.lastAcc == ACC_NONE)
    else $error("access made after a deselecting load");

  a_drive_read: assert property (
    dqOe |-> $past(st_q.lastAcc) == ACC_READ)
    else $error("outputs driven without a read at the edge before");

  a_pins_reg: assert property (
    reset_n |=> st_q.pins == $past(busIn))
    else $error("synchronous pins not registered");

  a_order_step: assert property (
    advance |=> st_q.accAddr[BURST_W-1:0] == (linearOrder ?
      BURST_W'(st_q.baseAddr[BURST_W-1:0] + st_q.burstCnt) :
      (st_q.baseAddr[BURST_W-1:0] ^ st_q.burstCnt)))
    else $error("burst step not in the strapped order");

endmodule
`default_nettype wire

/* File: pbs_host_model.sv */
// memory bus master model: drives the synchronous pins, resolves data wire
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model (
  input wire logic mclk,
  input wire logic [pbs_pkg::DATA_W-1:0] dqOut,
  input wire logic dqOe,
  output var pbs_pkg::pbs_bus_type busOut,
  output wire logic [pbs_pkg::DATA_W-1:0] dq
);
  import pbs_pkg::*;
  localparam logic [2:0] SEL = 3'h2;

  // ----------------------------------------------------------------
  // pins and shared wire
  // ----------------------------------------------------------------
  initial busOut = BUS_IDLE;
  // device drives while enabled, else the master's lines
  assign dq = dqOe ? dqOut : busOut.data;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // one cycle: pins change just after an edge, held to the next
  task automatic put(input logic [2:0] s, input logic [2:0] cs,
      input logic [ADDR_W-1:0] a, input logic [5:0] wr,
      input logic [DATA_W-1:0] d);
    {busOut.processorAddrStrobeN, busOut.controllerAddrStrobeN,
      busOut.burstAdvanceN} = s;
    {busOut.chipSelPipeN, busOut.chipSelDepthHi,
      busOut.chipSelDepthN} = cs;
    busOut.addr = a;
    {busOut.globalWriteN, busOut.byteWriteEnableN,
      busOut.byteLaneSelectN} = wr;
    // idle data lines flip so a stale value never reads back
    busOut.data = (wr == 6'h3f) ? ~busOut.data : d;
    @(posedge mclk);
    #1;
  endtask

  task automatic nop;
    put(3'h7, SEL, '0, 6'h3f, '0);
  endtask

  // controls and data ride with the strobe
  task automatic ctlWrite(input logic [ADDR_W-1:0] a, input logic [5:0] wr,
      input logic [DATA_W-1:0] d);
    put(3'h5, SEL, a, wr, d);
  endtask

  // strobe edge carries junk controls, second edge the real ones
  task automatic procWrite(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    put(3'h3, SEL, a, 6'h00, ~d);
    put(3'h7, SEL, a, 6'h0f, d);
  endtask

  // load, advance three times, collect four words
  task automatic burst(input logic [ADDR_W-1:0] a,
      output logic [DATA_W-1:0] w [4], output logic firstOe);
    put(3'h3, SEL, a, 6'h3f, '0);
    for (int i = 0; i < 5; i++) begin
      put((i < 3) ? 3'h6 : 3'h7, SEL, a, 6'h3f, '0);
      if (i == 0) begin
        firstOe = dqOe;
      end else begin
        w[i-1] = dq;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: pbs_sram_top_test.sv */
// self-checking bench of the sram front end with a bus master model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module pbs_sram_top_test;
  import pbs_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic outputEnableN = 1'b0;
  logic sleepRequest = 1'b0;
  logic burstOrderHi = 1'b1;
  pbs_bus_type busIn;
  logic [DATA_W-1:0] dqOut;
  logic dqOe;
  wire logic [DATA_W-1:0] dq;
  int failures = 0;
  int checksDone = 0;
  logic [DATA_W-1:0] w [4];
  logic firstOe;

  pbs_sram_top dut_u (.mclk(mclk), .reset_n(reset_n), .busIn(busIn),
    .outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
    .burstOrderHi(burstOrderHi), .dqOut(dqOut), .dqOe(dqOe));
  pbs_host_model host_u (.mclk(mclk), .dqOut(dqOut), .dqOe(dqOe),
    .busOut(busIn), .dq(dq));

  // 40 mhz clock
  always #12.5 mclk = ~mclk;

  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {~a, a};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // global writes of four words, deselect, burst from low pair 01
  task automatic t_burst(input logic [ADDR_W-1:0] base);
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      host_u.ctlWrite(ADDR_W'(base + i), 6'h1f, pat(ADDR_W'(base + i)));
    end
    host_u.put(3'h5, 3'h0, base, 6'h3f, '0);
    host_u.nop();
    host_u.burst(base | 16'h0001, w, firstOe);
    `CHK("first clock oe", 1'b0, firstOe)
    for (int i = 0; i < 4; i++) begin
      k = burstOrderHi ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
      `CHK("burst word", pat({base[15:2], k}), w[i])
    end
  endtask

  // byte lanes: global fill, two lanes, then disabled byte write
  task automatic t_lanes(input logic [ADDR_W-1:0] a);
    host_u.ctlWrite(a, 6'h1f, 32'hffffffff);
    host_u.ctlWrite(a, 6'h2a, 32'h11223344);
    `CHK("write float", 1'b0, dqOe)
    host_u.ctlWrite(a, 6'h30, 32'h00000000);
    host_u.burst(a, w, firstOe);
    `CHK("lane merge", 32'hff22ff44, w[0])
  endtask

  // processor write, strobe priority, ignored strobe, oe, sleep, deselect
  task automatic t_proc(input logic [ADDR_W-1:0] a);
    host_u.procWrite(a, 32'h5a5aa5a5);
    host_u.put(3'h1, 3'h2, a, 6'h1f, 32'hdeadbeef);
    host_u.nop();
    host_u.nop();
    `CHK("processor wins", 32'h5a5aa5a5, dq)
    host_u.put(3'h3, 3'h6, a ^ 16'h0004, 6'h3f, '0);
    host_u.nop();
    host_u.nop();
    `CHK("ignored strobe", 32'h5a5aa5a5, dq)
    `CHK("held drive", 1'b1, dqOe)
    outputEnableN = 1'b1;
    repeat (6) host_u.nop();
    `CHK("oe high float", 1'b0, dqOe)
    outputEnableN = 1'b0;
    repeat (6) host_u.nop();
    `CHK("oe low drive", 32'h5a5aa5a5, dq)
    sleepRequest = 1'b1;
    repeat (6) host_u.nop();
    `CHK("sleep float", 1'b0, dqOe)
    sleepRequest = 1'b0;
    repeat (6) host_u.nop();
    host_u.burst(a, w, firstOe);
    `CHK("sleep keeps", 32'h5a5aa5a5, w[0])
    host_u.put(3'h5, 3'h3, a, 6'h3f, '0);
    host_u.nop();
    host_u.nop();
    `CHK("deselect float", 1'b0, dqOe)
  endtask

  // ----------------------------------------------------------------
  // sequence, watchdog, verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main run, strap changed only under reset
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (6) host_u.nop();
    t_burst(16'h1230);
    t_lanes(16'h2340);
    t_proc(16'h3450);
    reset_n = 1'b0;
    burstOrderHi = 1'b0;
    repeat (6) host_u.nop();
    reset_n = 1'b1;
    repeat (6) host_u.nop();
    t_burst(16'h4560);
    report_and_stop();
  end

  // hang guard, far beyond the 112 or so cycles of the run
  initial begin
    #(25 * 4000);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
